// >>> logic/bar_pkg.sv
// package of constants and carrier types for the bit alias remapper
package bar_pkg;
   localparam logic [31:0] BAR_SRAM_BASE = 32'h2000_0000;
   localparam logic [31:0] BAR_PERI_BASE = 32'h4000_0000;
   localparam logic [31:0] BAR_SRAM_ALIAS = 32'h2200_0000;
   localparam logic [31:0] BAR_PERI_ALIAS = 32'h4200_0000;
   localparam int BAR_WIN_POS = 25; // alias window is 32 MB
   localparam int BAR_BYTE_POS = 5; // byte offset times 32
   localparam int BAR_BIT_POS = 2; // bit number times 4
   localparam int BAR_BIT_W = 3;
   localparam int BAR_OFS_W = 20; // 1 MB bit window
   localparam logic [31:0] BAR_RDATA_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      BAR_SIZE_BYTE = 2'b00,
      BAR_SIZE_HALF = 2'b01,
      BAR_SIZE_WORD = 2'b10
   } bar_size_type;

   typedef enum logic [1:0] {
      BAR_IDLE = 2'b00,
      BAR_READ = 2'b01,
      BAR_WRITE = 2'b10,
      BAR_DONE = 2'b11
   } bar_state_type;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic fetch;
      bar_size_type size;
      logic [31:0] wdata;
   } bar_req_type;

   typedef struct packed {
      logic [31:0] rdata;
      logic error;
   } bar_rsp_type;
endpackage : bar_pkg

// >>> logic/bar_decode.sv
// alias window decoder: splits an alias address into target byte and bit
`timescale 1ns/100ps
module bar_decode (
   // request address and kind
   input wire logic [31:0] addr_i,
   input wire logic fetch_i,
   // decode results
   output logic alias_o,
   output logic refuse_o,
   output logic [31:0] byte_addr_o,
   output logic [bar_pkg::BAR_BIT_W-1:0] bit_o
);
   import bar_pkg::*;
   logic in_sram;
   logic in_peri;
   // window hits on the top seven address bits
   assign in_sram = addr_i[31:BAR_WIN_POS] == BAR_SRAM_ALIAS[31:BAR_WIN_POS];
   assign in_peri = addr_i[31:BAR_WIN_POS] == BAR_PERI_ALIAS[31:BAR_WIN_POS];
   assign alias_o = (in_sram || in_peri) && !fetch_i;
   assign refuse_o = in_peri && fetch_i;
   // inverse of base plus byte times 32 plus bit times 4
   assign bit_o = addr_i[BAR_BYTE_POS-1:BAR_BIT_POS];
   assign byte_addr_o = (in_peri ? BAR_PERI_BASE : BAR_SRAM_BASE)
                      | {12'h000, addr_i[BAR_OFS_W+BAR_BYTE_POS-1:BAR_BYTE_POS]};
endmodule : bar_decode

// >>> logic/bar_lane.sv
// byte lane helper: reads and rewrites one bit of a little endian word
`timescale 1ns/100ps
module bar_lane (
   // word and target
   input wire logic [31:0] word_i,
   input wire logic [1:0] lane_i,
   input wire logic [bar_pkg::BAR_BIT_W-1:0] bit_i,
   input wire logic value_i,
   // results
   output logic bit_o,
   output logic [31:0] word_o
);
   import bar_pkg::*;
   logic [4:0] pos;
   // byte lane n holds bits 8n+7..8n
   assign pos = {lane_i, bit_i};
   assign bit_o = word_i[pos];
   // only the target bit is replaced
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_bit
         assign word_o[g] = (pos == 5'(g)) ? value_i : word_i[g];
      end
   endgenerate
endmodule : bar_lane

// >>> logic/bar_remap.sv
// bit alias remapper between the processor data bus and the memory system
`timescale 1ns/100ps
module bar_remap (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic enable_i,
   // processor side
   input wire logic cpu_valid_i,
   input wire bar_pkg::bar_req_type cpu_req_i,
   output logic cpu_ready_o,
   output bar_pkg::bar_rsp_type cpu_rsp_o,
   // memory side
   output logic mem_valid_o,
   output bar_pkg::bar_req_type mem_req_o,
   input wire logic mem_ready_i,
   input wire logic [31:0] mem_rdata_i
);
   import bar_pkg::*;

   // access flow, one request at a time
   //    direct read or write: idle, one memory phase, done
   //    alias read: idle, read phase, done with 0 or 1 as data
   //    alias write: idle, read phase, write phase, done
   //    refused fetch: idle, done with the error bit, no memory phase
   // alias address layout, per window
   //    bits 24 to 5 give the byte offset inside the 1 MB bit window
   //    bits 4 to 2 give the bit number inside that byte
   //    bits 1 to 0 are dropped, so every alias word names one bit
   // the byte offset lands in the low bits of the memory address, so the
   // memory sees the byte lane in bits 1 to 0 and the size of the request
   // done lasts one cycle and carries the ready strobe to the processor;
   // the processor drops valid in the done cycle, or the request is taken again
   // a low enable stalls the sequencer but not the memory, so enable must
   // not drop while a memory phase is open

   // sequencer state
   bar_state_type state;

   // captured request; alias requests hold the byte address here
   bar_req_type req;
   bar_req_type next_req;
   logic is_alias;
   logic next_is_alias;
   logic rmw;
   logic next_rmw;
   logic [BAR_BIT_W-1:0] tgt_bit;
   logic [BAR_BIT_W-1:0] next_tgt_bit;

   // response registers and their next values
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic error;
   logic next_error;

   // write word of a read-modify-write, built in the read phase
   logic [31:0] wr_word;
   logic [31:0] next_wr_word;

   // decode of the incoming request
   logic dec_alias;
   logic dec_refuse;
   logic [31:0] dec_byte;
   logic [BAR_BIT_W-1:0] dec_bit;

   // lane helper inputs and results
   logic [1:0] lane;
   logic new_bit;
   logic lane_bit;
   logic [31:0] lane_word;

   // strobes of the current cycle
   logic idle;
   logic take;
   logic take_ok;
   logic take_refuse;
   logic in_read;
   logic in_write;
   logic in_done;
   logic read_done;
   logic write_done;

   // memory side drive
   logic [31:0] mem_addr;
   logic mem_write;
   logic [31:0] mem_wdata;

   // address decode of the incoming request
   bar_decode u_decode (
      .addr_i(cpu_req_i.addr),
      .fetch_i(cpu_req_i.fetch),
      .alias_o(dec_alias),
      .refuse_o(dec_refuse),
      .byte_addr_o(dec_byte),
      .bit_o(dec_bit)
   );

   // byte lane of the target in the read word, and the value it takes
   assign lane = req.addr[1:0];
   assign new_bit = req.wdata[0];

   // bit extraction and insertion on the memory read data
   bar_lane u_lane (
      .word_i(mem_rdata_i),
      .lane_i(lane),
      .bit_i(tgt_bit),
      .value_i(new_bit),
      .bit_o(lane_bit),
      .word_o(lane_word)
   );

   // a request is taken only while running and idle
   assign idle = (state == BAR_IDLE);
   assign take = enable_i && idle && cpu_valid_i;
   assign take_ok = take && !dec_refuse;
   assign take_refuse = take && dec_refuse;

   // phase decode, and phase completion gated by the clock enable
   assign in_read = (state == BAR_READ);
   assign in_write = (state == BAR_WRITE);
   assign in_done = (state == BAR_DONE);
   assign read_done = enable_i && in_read && mem_ready_i;
   assign write_done = enable_i && in_write && mem_ready_i;

   // next captured request: size and data kept, alias address swapped for the byte address
   always_comb begin
      next_req = cpu_req_i;
      if (dec_alias) begin
         next_req.addr = dec_byte;
      end
   end

   // request register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req <= '0;
      end else if (take_ok) begin
         req <= next_req;
      end
   end

   // alias flag: picks the response source
   always_comb begin
      next_is_alias = is_alias;
      if (take_ok) begin
         next_is_alias = dec_alias;
      end
   end

   // alias flag register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         is_alias <= 1'b0;
      end else if (enable_i) begin
         is_alias <= next_is_alias;
      end
   end

   // read-modify-write flag: alias writes only, fetches never decode as alias
   always_comb begin
      next_rmw = rmw;
      if (take_ok) begin
         next_rmw = dec_alias && cpu_req_i.write;
      end
   end

   // read-modify-write flag register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rmw <= 1'b0;
      end else if (enable_i) begin
         rmw <= next_rmw;
      end
   end

   // target bit number within the addressed byte
   always_comb begin
      next_tgt_bit = tgt_bit;
      if (take_ok) begin
         next_tgt_bit = dec_bit;
      end
   end

   // target bit register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tgt_bit <= '0;
      end else if (enable_i) begin
         tgt_bit <= next_tgt_bit;
      end
   end

   // sequencer: one memory phase, or read then write for alias writes
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= BAR_IDLE;
      end else if (enable_i) begin
         case (state)
            BAR_IDLE: begin
               // refused fetches skip the memory entirely
               if (take_refuse) begin
                  state <= BAR_DONE;
               end else if (take_ok) begin
                  state <= BAR_READ;
               end
            end
            BAR_READ: begin
               // direct writes also complete in this phase
               if (read_done) begin
                  state <= rmw ? BAR_WRITE : BAR_DONE;
               end
            end
            BAR_WRITE: begin
               // only alias writes come here, after their read phase
               if (write_done) begin
                  state <= BAR_DONE;
               end
            end
            BAR_DONE: begin
               // ready stands for this one cycle
               state <= BAR_IDLE;
            end
            default: begin
               // unused code, back to idle
               state <= BAR_IDLE;
            end
         endcase
      end
   end

   // response data: cleared on take, loaded at the end of the read phase of a read request
   always_comb begin
      next_rdata = rdata;
      if (take) begin
         next_rdata = BAR_RDATA_RST;
      end else if (read_done && !req.write) begin
         // alias reads answer 0 or 1, direct reads pass the word
         next_rdata = is_alias ? {31'h0000_0000, lane_bit} : mem_rdata_i;
      end
   end

   // response data register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata <= BAR_RDATA_RST;
      end else if (enable_i) begin
         rdata <= next_rdata;
      end
   end

   // error: a refused fetch sets it, any other take clears it
   always_comb begin
      next_error = error;
      if (take) begin
         next_error = dec_refuse;
      end
   end

   // error register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         error <= 1'b0;
      end else if (enable_i) begin
         error <= next_error;
      end
   end

   // write word: the read word with only the target bit replaced, held so the
   // write phase never relies on read data shown by the memory during a write
   always_comb begin
      next_wr_word = wr_word;
      if (read_done && rmw) begin
         next_wr_word = lane_word;
      end
   end

   // write word register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_word <= '0;
      end else if (enable_i) begin
         wr_word <= next_wr_word;
      end
   end

   // memory address: byte address for alias accesses, untouched otherwise
   assign mem_addr = req.addr;

   // write strobe: write phase of an alias write, or the single phase of a direct write
   assign mem_write = in_write || (in_read && !rmw && req.write);

   // write data: rebuilt word in the write phase, processor data otherwise
   assign mem_wdata = in_write ? wr_word : req.wdata;

   // a memory phase is open in the read and write states
   assign mem_valid_o = in_read || in_write;

   // memory request carrier
   always_comb begin
      mem_req_o = req;
      mem_req_o.addr = mem_addr;
      mem_req_o.write = mem_write;
      mem_req_o.wdata = mem_wdata;
   end

   // processor answer: ready for one cycle in done, data from registers
   assign cpu_ready_o = in_done;
   assign cpu_rsp_o.rdata = rdata;
   assign cpu_rsp_o.error = error;
endmodule : bar_remap

// >>> verif/bar_remap_assertions.sv
// port checker for the bit alias remapper
`timescale 1ns/100ps
module bar_remap_assertions (
   // watched ports
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic cpu_valid_i,
   input wire bar_pkg::bar_req_type cpu_req_i,
   input wire logic cpu_ready_o,
   input wire bar_pkg::bar_rsp_type cpu_rsp_o,
   input wire logic mem_valid_o,
   input wire bar_pkg::bar_req_type mem_req_o,
   input wire logic mem_ready_i,
   input wire logic [31:0] mem_rdata_i
);
   import bar_pkg::*;
   logic [31:0] rd_q;
   wire sa = cpu_req_i.addr[31:25] == 7'h11;
   wire pa = cpu_req_i.addr[31:25] == 7'h21;
   wire rm = !cpu_req_i.fetch && (sa || pa);
   wire [4:0] ix = cpu_req_i.addr[6:2];
   // last word the memory answered with
   always_ff @(posedge clock_i or negedge rst_b_i)
      if (!rst_b_i) rd_q <= '0;
      else if (mem_ready_i) rd_q <= mem_rdata_i;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i);
   sram_map_a: assert property (
      mem_valid_o && rm && sa |-> mem_req_o.addr == BAR_SRAM_BASE + cpu_req_i.addr[24:5]) else $error("sram map");
   peri_map_a: assert property (
      mem_valid_o && rm && pa |-> mem_req_o.addr == BAR_PERI_BASE + cpu_req_i.addr[24:5]) else $error("peri map");
   size_keep_a: assert property (
      mem_valid_o |-> mem_req_o.size == cpu_req_i.size) else $error("size");
   pass_thru_a: assert property (
      mem_valid_o && !rm |-> mem_req_o == cpu_req_i) else $error("pass");
   fetch_deny_a: assert property (
      $rose(cpu_valid_i) && cpu_req_i.fetch && pa |-> !mem_valid_o ##1 cpu_ready_o && cpu_rsp_o == 33'h1)
      else $error("fetch");
   bit_read_a: assert property (
      cpu_ready_o && rm && !cpu_req_i.write |-> cpu_rsp_o.rdata == {31'h0, rd_q[ix]}) else $error("read");
   rmw_data_a: assert property (
      mem_valid_o && mem_ready_i && mem_req_o.write && rm |->
      mem_req_o.wdata == ((rd_q & ~(32'h1 << ix)) | (32'(cpu_req_i.wdata[0]) << ix))) else $error("rmw data");
   rmw_order_a: assert property (
      $rose(mem_valid_o) && rm && cpu_req_i.write |->
      !mem_req_o.write ##[1:8] mem_valid_o && mem_ready_i && mem_req_o.write) else $error("rmw order");
endmodule : bar_remap_assertions
bind bar_remap bar_remap_assertions u_chk (.clock_i, .rst_b_i, .cpu_valid_i, .cpu_req_i, .cpu_ready_o,
   .cpu_rsp_o, .mem_valid_o, .mem_req_o, .mem_ready_i, .mem_rdata_i);

// >>> verif/bar_mem_model.sv
// memory model answering the remapper's memory side
`timescale 1ns/100ps
module bar_mem_model (
   // memory side
   input wire logic clock_i,
   input wire logic slow_i,
   input wire logic mem_valid_i,
   input wire bar_pkg::bar_req_type mem_req_i,
   output logic mem_ready_o,
   output logic [31:0] mem_rdata_o
);
   logic [31:0] mem [0:255];
   logic [1:0] wait_cnt = 2'h0;
   wire [7:0] ix = mem_req_i.addr[9:2];
   initial foreach (mem[i]) mem[i] = 32'h5A5A_A5A5;
   // answer at once, or after two wait cycles when slow
   assign mem_ready_o = mem_valid_i && (!slow_i || wait_cnt == 2'h2);
   // outside the answer cycle the lines show the inverse, never stale data
   assign mem_rdata_o = mem_ready_o ? mem[ix] : ~mem[ix];
   // count waits and store written words
   always @(posedge clock_i) begin
      wait_cnt <= (mem_valid_i && !mem_ready_o) ? wait_cnt + 2'h1 : 2'h0;
      if (mem_ready_o && mem_req_i.write) mem[ix] <= mem_req_i.wdata;
   end
endmodule : bar_mem_model

// >>> verif/bar_remap_bench.sv
// self-checking bench for the bit alias remapper
`timescale 1ns/100ps
module bar_remap_bench;
   import bar_pkg::*;
   localparam logic [31:0] FILL = 32'h5A5A_A5A5;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic cpu_valid_i = 1'b0;
   logic slow = 1'b0;
   logic enable = 1'b1;
   bar_req_type cpu_req_i = '0;
   bar_req_type mem_req_o;
   bar_rsp_type cpu_rsp_o;
   logic cpu_ready_o;
   logic mem_valid_o;
   logic mem_ready_i;
   logic [31:0] mem_rdata_i;
   int error_cnt = 0;
   int tests_run = 0;
   always #25 clock_i = ~clock_i;
   bar_remap u_dut (.clock_i, .rst_b_i, .enable_i(enable), .cpu_valid_i, .cpu_req_i, .cpu_ready_o, .cpu_rsp_o,
      .mem_valid_o, .mem_req_o, .mem_ready_i, .mem_rdata_i);
   bar_mem_model u_mem (.clock_i, .slow_i(slow), .mem_valid_i(mem_valid_o), .mem_req_i(mem_req_o),
      .mem_ready_o(mem_ready_i), .mem_rdata_o(mem_rdata_i));
   task automatic test_done;
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   // one request held until the answer, then released
   task automatic access(input logic [31:0] a, input logic w, input logic f, input bar_size_type sz,
      input logic [31:0] d, output bar_rsp_type r);
      int n = 0;
      @(posedge clock_i);
      cpu_req_i <= '{addr: a, write: w, fetch: f, size: sz, wdata: d};
      cpu_valid_i <= 1'b1;
      do begin
         @(negedge clock_i);
         n++;
      end while (cpu_ready_o !== 1'b1 && n < 20);
      if (cpu_ready_o !== 1'b1) error_cnt++;
      r = cpu_rsp_o;
      @(posedge clock_i);
      cpu_valid_i <= 1'b0;
   endtask : access
   // set and clear one bit through its alias, read back both ways
   task automatic alias_bit(input logic [31:0] ab, input logic [31:0] db, input int byt, input int bt,
      input bar_size_type sz);
      logic [31:0] al = ab + 32'(byt * 32 + bt * 4);
      logic [31:0] dw = db + 32'(byt & ~3);
      logic [31:0] m = 32'h1 << ((byt % 4) * 8 + bt);
      bar_rsp_type r;
      access(al, 1'b1, 1'b0, sz, 32'h0000_00FF, r);
      access(al, 1'b0, 1'b0, sz, 32'h0, r);
      check(r, 33'h2);
      access(dw, 1'b0, 1'b0, BAR_SIZE_WORD, 32'h0, r);
      check(r, {FILL | m, 1'b0});
      access(al, 1'b1, 1'b0, sz, 32'h0000_000E, r);
      access(al, 1'b0, 1'b0, sz, 32'h0, r);
      check(r, 33'h0);
      access(dw, 1'b0, 1'b0, BAR_SIZE_WORD, 32'h0, r);
      check(r, {FILL & ~m, 1'b0});
   endtask : alias_bit
   // fetches into both alias windows, then a direct write seen through the alias
   task automatic fetch_direct;
      bar_rsp_type r;
      access(32'h4200_0000, 1'b0, 1'b1, BAR_SIZE_WORD, 32'h0, r);
      check(r, 33'h1);
      access(32'h2200_0010, 1'b0, 1'b1, BAR_SIZE_WORD, 32'h0, r);
      check(r, {FILL, 1'b0});
      access(32'h2000_0008, 1'b1, 1'b0, BAR_SIZE_WORD, 32'h0000_0100, r);
      access(32'h2200_0120, 1'b0, 1'b0, BAR_SIZE_WORD, 32'h0, r);
      check(r, 33'h2);
   endtask : fetch_direct
   // a frozen block neither answers nor opens a memory phase, then resumes
   task automatic freeze_read;
      bar_rsp_type r;
      int busy = 0;
      enable <= 1'b0;
      fork
         access(32'h2200_0120, 1'b0, 1'b0, BAR_SIZE_WORD, 32'h0, r);
         begin
            repeat (6) begin
               @(negedge clock_i);
               if (cpu_ready_o !== 1'b0 || mem_valid_o !== 1'b0) busy++;
            end
            @(posedge clock_i);
            enable <= 1'b1;
         end
      join
      check({32'(busy), 1'b0}, 33'h0);
      check(r, 33'h2);
   endtask : freeze_read
   initial begin
      repeat (20) @(posedge clock_i);
      rst_b_i <= 1'b1;
      alias_bit(BAR_SRAM_ALIAS, BAR_SRAM_BASE, 1, 3, BAR_SIZE_WORD);
      slow <= 1'b1;
      alias_bit(BAR_PERI_ALIAS, BAR_PERI_BASE, 6, 7, BAR_SIZE_BYTE);
      fetch_direct();
      freeze_read();
      test_done();
   end
   // cut a hang short
   initial begin
      #100us;
      error_cnt++;
      test_done();
   end
endmodule : bar_remap_bench
